/* File: hw/atre_map.svh */
`ifndef ATRE_MAP_SVH
`define ATRE_MAP_SVH

// register port offsets
`define ATRE_REG_ACC 4'h0
`define ATRE_REG_STATUS 4'h1
`define ATRE_REG_BANK 4'h2
`define ATRE_REG_PTR_LO 4'h3
`define ATRE_REG_PTR_HI 4'h4
`define ATRE_REG_PTR_UP 4'h5
`define ATRE_REG_LATCH 4'h6
`define ATRE_REG_CTRL 4'h7
`define ATRE_REG_IDX_LO 4'h8
`define ATRE_REG_IDX_HI 4'h9

// flag positions in the status register
`define ATRE_FLG_C 0
`define ATRE_FLG_DIGIT_CARRY 1
`define ATRE_FLG_Z 2
`define ATRE_FLG_OVERFLOW 3
`define ATRE_FLG_N 4

// control register fields
`define ATRE_CTRL_EXT 0
`define ATRE_CTRL_BUSY 7

// opcode fields
`define ATRE_OP_ADDC 6'h08
`define ATRE_OP_ANDL 8'h0b
`define ATRE_OP_TBL 14'h0002
`define ATRE_BIT_DEST 9
`define ATRE_BIT_BANKED 8

// table pointer update modes
`define ATRE_TBL_KEEP 2'h0
`define ATRE_TBL_POSTINC 2'h1
`define ATRE_TBL_POSTDEC 2'h2
`define ATRE_TBL_PREINC 2'h3

// access bank split, upper and lower bank
`define ATRE_ACCESS_LIMIT 8'h5f
`define ATRE_ACCESS_HI_BANK 4'hf
`define ATRE_ACCESS_LO_BANK 4'h0

// quarter phases of an instruction cycle
`define ATRE_PH_DEC 2'h0
`define ATRE_PH_READ 2'h1
`define ATRE_PH_PROC 2'h2
`define ATRE_PH_WRITE 2'h3
`define ATRE_PH_STEP 2'h1

`define ATRE_PTR_STEP 21'h000001
`define ATRE_BYTE_ZERO 8'h00

`endif

/* File: hw/atre_pkg.sv */
package atre_pkg;

typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CYC1 = 3'b010,
    ST_CYC2 = 3'b100
} atre_fsm_t;

typedef enum logic [1:0] {
    K_NOP = 2'h0,
    K_ADDC = 2'h1,
    K_ANDL = 2'h2,
    K_TBL = 2'h3
} atre_kind_t;

typedef struct packed {
    atre_fsm_t fsm;
    logic [1:0] phase;
    atre_kind_t kind;
    logic [15:0] instr;
    logic [7:0] acc;
    logic [4:0] status;
    logic [3:0] bankSel;
    logic [20:0] ptr;
    logic [7:0] latch;
    logic ext;
    logic [11:0] idx;
    logic [15:0] operand;
    logic busy;
    logic [7:0] rdata;
    logic [11:0] dmAddr;
    logic dmRd;
    logic dmWr;
    logic [7:0] dmWdata;
    logic [19:0] pmAddr;
    logic pmRd;
} atre_state_t;

localparam atre_state_t ATRE_STATE_RST = '{fsm: ST_IDLE, kind: K_NOP, default: '0};

endpackage

/* File: hw/atre_alu_if.sv */
`timescale 1ns/10ps
interface atre_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic carryIn;
    logic opAnd;
    logic [7:0] result;
    logic neg;
    logic ovf;
    logic zero;
    logic digitCarry;
    logic carryOut;

    modport core (output a, b, carryIn, opAnd,
                  input result, neg, ovf, zero, digitCarry, carryOut);
    modport alu (input a, b, carryIn, opAnd,
                 output result, neg, ovf, zero, digitCarry, carryOut);
endinterface

/* File: hw/atre_alu.sv */
`timescale 1ns/10ps
module atre_alu (
    // operands and flags
    atre_alu_if.alu bus
);
    logic [8:0] full;
    logic [4:0] low;

    assign full = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.carryIn};
    assign low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.carryIn};
    assign bus.result = bus.opAnd ? (bus.a & bus.b) : full[7:0];
    assign bus.neg = bus.result[7];
    assign bus.zero = (bus.result == 8'h00);
    assign bus.carryOut = full[8];
    assign bus.digitCarry = low[4];
    // signed overflow: equal operand signs, different result sign
    assign bus.ovf = (bus.a[7] == bus.b[7]) && (full[7] != bus.a[7]);
endmodule

/* File: hw/atre_core.sv */
// Summary of operation
// - add accumulator, file operand and carry
// - destination bit picks accumulator or file
// - bank bit picks access bank or bank
// - indexed offset when unbanked, extended, low address
// - and literal into accumulator
// - program memory addressed by 21-bit pointer
// - pointer bit zero selects word byte
// - low opcode bits select pointer update
// - pre-increment bumps pointer before reading
// - table read takes two cycles
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "atre_map.svh"
module atre_core
    import atre_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // instruction port
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    output logic busy,
    // data memory
    output logic [11:0] dmAddr,
    output logic dmRd,
    output logic dmWr,
    output logic [7:0] dmWdata,
    input wire logic [7:0] dmRdata,
    // program memory
    output logic [19:0] pmAddr,
    output logic pmRd,
    input wire logic [15:0] pmRdata
);
    atre_state_t s_q;
    atre_state_t s_d;
    atre_alu_if aluBus ();

    atre_alu u_alu (
        .bus(aluBus)
    );

    function automatic atre_kind_t decodeKind(input logic [15:0] w);
        if (w[15:10] == `ATRE_OP_ADDC) begin
            return K_ADDC;
        end else if (w[15:8] == `ATRE_OP_ANDL) begin
            return K_ANDL;
        end else if (w[15:2] == `ATRE_OP_TBL) begin
            return K_TBL;
        end
        return K_NOP;
    endfunction

    // operand address from the file field, bank bit and mode
    function automatic logic [11:0] fileAddr(input logic [15:0] w, input logic ext,
                                             input logic [3:0] bankSel, input logic [11:0] idx);
        if (w[`ATRE_BIT_BANKED]) begin
            return {bankSel, w[7:0]};
        end else if (w[7:0] <= `ATRE_ACCESS_LIMIT) begin
            if (ext) begin
                return 12'(idx + {4'h0, w[7:0]});
            end
            return {`ATRE_ACCESS_LO_BANK, w[7:0]};
        end
        return {`ATRE_ACCESS_HI_BANK, w[7:0]};
    endfunction

    assign aluBus.a = s_q.acc;
    assign aluBus.b = (s_q.kind == K_ANDL) ? s_q.instr[7:0] : s_q.operand[7:0];
    assign aluBus.carryIn = s_q.status[`ATRE_FLG_C];
    assign aluBus.opAnd = (s_q.kind == K_ANDL);

    always_comb begin
        s_d = s_q;
        s_d.dmRd = 1'b0;
        s_d.dmWr = 1'b0;
        s_d.pmRd = 1'b0;
        s_d.rdata = `ATRE_BYTE_ZERO;
        // software writes first so a same-cycle core update wins
        if (regWr) begin
            case (regAddr)
                `ATRE_REG_ACC: s_d.acc = regWdata;
                `ATRE_REG_STATUS: s_d.status = regWdata[4:0];
                `ATRE_REG_BANK: s_d.bankSel = regWdata[3:0];
                `ATRE_REG_PTR_LO: s_d.ptr[7:0] = regWdata;
                `ATRE_REG_PTR_HI: s_d.ptr[15:8] = regWdata;
                `ATRE_REG_PTR_UP: s_d.ptr[20:16] = regWdata[4:0];
                `ATRE_REG_LATCH: s_d.latch = regWdata;
                `ATRE_REG_CTRL: s_d.ext = regWdata[`ATRE_CTRL_EXT];
                `ATRE_REG_IDX_LO: s_d.idx[7:0] = regWdata;
                `ATRE_REG_IDX_HI: s_d.idx[11:8] = regWdata[3:0];
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                `ATRE_REG_ACC: s_d.rdata = s_q.acc;
                `ATRE_REG_STATUS: s_d.rdata = {3'h0, s_q.status};
                `ATRE_REG_BANK: s_d.rdata = {4'h0, s_q.bankSel};
                `ATRE_REG_PTR_LO: s_d.rdata = s_q.ptr[7:0];
                `ATRE_REG_PTR_HI: s_d.rdata = s_q.ptr[15:8];
                `ATRE_REG_PTR_UP: s_d.rdata = {3'h0, s_q.ptr[20:16]};
                `ATRE_REG_LATCH: s_d.rdata = s_q.latch;
                `ATRE_REG_CTRL: s_d.rdata = {s_q.busy, 6'h00, s_q.ext};
                `ATRE_REG_IDX_LO: s_d.rdata = s_q.idx[7:0];
                `ATRE_REG_IDX_HI: s_d.rdata = {4'h0, s_q.idx[11:8]};
                default: s_d.rdata = `ATRE_BYTE_ZERO;
            endcase
        end
        unique case (s_q.fsm)
            ST_IDLE: begin
                if (instrValid) begin
                    s_d.instr = instrWord;
                    s_d.kind = decodeKind(instrWord);
                    s_d.fsm = ST_CYC1;
                    s_d.phase = `ATRE_PH_DEC;
                end
            end
            ST_CYC1: begin
                s_d.phase = s_q.phase + `ATRE_PH_STEP;
                unique case (s_q.phase)
                    `ATRE_PH_DEC: begin
                        if (s_q.kind == K_ADDC) begin
                            s_d.dmRd = 1'b1;
                            s_d.dmAddr = fileAddr(s_q.instr, s_q.ext, s_q.bankSel, s_q.idx);
                        end
                    end
                    `ATRE_PH_READ: ;
                    `ATRE_PH_PROC: begin
                        if (s_q.kind == K_ADDC) begin
                            s_d.operand = {8'h00, dmRdata};
                        end
                    end
                    `ATRE_PH_WRITE: begin
                        s_d.fsm = (s_q.kind == K_TBL) ? ST_CYC2 : ST_IDLE;
                        if (s_q.kind == K_ADDC) begin
                            s_d.status[`ATRE_FLG_N] = aluBus.neg;
                            s_d.status[`ATRE_FLG_OVERFLOW] = aluBus.ovf;
                            s_d.status[`ATRE_FLG_Z] = aluBus.zero;
                            s_d.status[`ATRE_FLG_DIGIT_CARRY] = aluBus.digitCarry;
                            s_d.status[`ATRE_FLG_C] = aluBus.carryOut;
                            if (s_q.instr[`ATRE_BIT_DEST]) begin
                                s_d.dmWr = 1'b1;
                                s_d.dmWdata = aluBus.result;
                            end else begin
                                s_d.acc = aluBus.result;
                            end
                        end else if (s_q.kind == K_ANDL) begin
                            s_d.acc = aluBus.result;
                            s_d.status[`ATRE_FLG_N] = aluBus.neg;
                            s_d.status[`ATRE_FLG_Z] = aluBus.zero;
                        end else if (s_q.kind == K_TBL) begin
                            if (s_q.instr[1:0] == `ATRE_TBL_PREINC) begin
                                s_d.ptr = s_q.ptr + `ATRE_PTR_STEP;
                            end
                        end
                    end
                endcase
            end
            ST_CYC2: begin
                s_d.phase = s_q.phase + `ATRE_PH_STEP;
                unique case (s_q.phase)
                    `ATRE_PH_DEC: begin
                        s_d.pmRd = 1'b1;
                        s_d.pmAddr = s_q.ptr[20:1];
                    end
                    `ATRE_PH_READ: ;
                    `ATRE_PH_PROC: s_d.operand = pmRdata;
                    `ATRE_PH_WRITE: begin
                        // latch written at end of second cycle
                        s_d.fsm = ST_IDLE;
                        // byte select by pointer bit zero
                        s_d.latch = s_q.ptr[0] ? s_q.operand[15:8] : s_q.operand[7:0];
                        if (s_q.instr[1:0] == `ATRE_TBL_POSTINC) begin
                            s_d.ptr = s_q.ptr + `ATRE_PTR_STEP;
                        end else if (s_q.instr[1:0] == `ATRE_TBL_POSTDEC) begin
                            s_d.ptr = s_q.ptr - `ATRE_PTR_STEP;
                        end
                    end
                endcase
            end
        endcase
        s_d.busy = (s_d.fsm != ST_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= ATRE_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdata;
    assign busy = s_q.busy;
    assign dmAddr = s_q.dmAddr;
    assign dmRd = s_q.dmRd;
    assign dmWr = s_q.dmWr;
    assign dmWdata = s_q.dmWdata;
    assign pmAddr = s_q.pmAddr;
    assign pmRd = s_q.pmRd;

    // checking
    logic accept;
    logic wr1;
    logic wr2;
    assign accept = (s_q.fsm == ST_IDLE) && instrValid;
    assign wr1 = (s_q.fsm == ST_CYC1) && (s_q.phase == `ATRE_PH_WRITE);
    assign wr2 = (s_q.fsm == ST_CYC2) && (s_q.phase == `ATRE_PH_WRITE);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_ADDC_SUM: assert property (
        wr1 && s_q.kind == K_ADDC && !s_q.instr[`ATRE_BIT_DEST] && !regWr |=>
        s_q.acc == 8'($past(s_q.acc) + $past(s_q.operand[7:0])
                      + {7'h00, $past(s_q.status[`ATRE_FLG_C])}))
        else $error("add result wrong");
    AST_ADDC_DEST: assert property (
        wr1 && s_q.kind == K_ADDC && s_q.instr[`ATRE_BIT_DEST] && !regWr |=>
        dmWr && $stable(s_q.acc) && dmAddr == $past(dmAddr))
        else $error("file destination not written");
    AST_BANKED: assert property (
        s_q.fsm == ST_CYC1 && s_q.phase == `ATRE_PH_DEC && s_q.kind == K_ADDC
        && s_q.instr[`ATRE_BIT_BANKED] |=>
        dmRd && dmAddr == {$past(s_q.bankSel), $past(s_q.instr[7:0])})
        else $error("banked address wrong");
    AST_INDEXED: assert property (
        s_q.fsm == ST_CYC1 && s_q.phase == `ATRE_PH_DEC && s_q.kind == K_ADDC
        && !s_q.instr[`ATRE_BIT_BANKED] && s_q.ext
        && s_q.instr[7:0] <= `ATRE_ACCESS_LIMIT |=>
        dmAddr == 12'($past(s_q.idx) + {4'h0, $past(s_q.instr[7:0])}))
        else $error("indexed address wrong");
    AST_ONE_CYCLE: assert property (
        accept && decodeKind(instrWord) != K_TBL |=> busy [*4] ##1 !busy)
        else $error("single cycle instruction length wrong");
    AST_ANDL: assert property (
        wr1 && s_q.kind == K_ANDL && !regWr |=>
        s_q.acc == ($past(s_q.acc) & $past(s_q.instr[7:0])))
        else $error("and result wrong");
    AST_ANDL_FLAGS: assert property (
        wr1 && s_q.kind == K_ANDL && !regWr |=>
        s_q.status[`ATRE_FLG_OVERFLOW] == $past(s_q.status[`ATRE_FLG_OVERFLOW])
        && s_q.status[`ATRE_FLG_DIGIT_CARRY] == $past(s_q.status[`ATRE_FLG_DIGIT_CARRY])
        && s_q.status[`ATRE_FLG_C] == $past(s_q.status[`ATRE_FLG_C]))
        else $error("and touched other flags");
    AST_PM_ADDR: assert property (
        s_q.fsm == ST_CYC2 && s_q.phase == `ATRE_PH_DEC |=>
        pmRd && pmAddr == $past(s_q.ptr[20:1]))
        else $error("program address wrong");
    AST_BYTE_SEL: assert property (
        wr2 && !regWr |=> s_q.latch == ($past(s_q.ptr[0]) ?
                          $past(s_q.operand[15:8]) : $past(s_q.operand[7:0])))
        else $error("latch byte wrong");
    AST_POST_MODE: assert property (
        wr2 && !regWr && s_q.instr[1:0] == `ATRE_TBL_POSTDEC |=>
        s_q.ptr == 21'($past(s_q.ptr) - `ATRE_PTR_STEP))
        else $error("post decrement wrong");
    AST_PREINC: assert property (
        wr1 && s_q.kind == K_TBL && !regWr && s_q.instr[1:0] == `ATRE_TBL_PREINC |=>
        s_q.ptr == 21'($past(s_q.ptr) + `ATRE_PTR_STEP)
        ##1 pmRd && pmAddr == $past(s_q.ptr[20:1]))
        else $error("pre increment wrong");
    AST_TBL_LEN: assert property (
        accept && decodeKind(instrWord) == K_TBL |=> busy [*8] ##1 !busy)
        else $error("table read length wrong");

    COV_ADDC_FILE: cover property (wr1 && s_q.kind == K_ADDC && s_q.instr[`ATRE_BIT_DEST]);
    COV_ANDL: cover property (wr1 && s_q.kind == K_ANDL);
    COV_TBL_PRE: cover property (wr2 && s_q.instr[1:0] == `ATRE_TBL_PREINC);
    COV_INDEXED: cover property (dmRd && s_q.ext && !s_q.instr[`ATRE_BIT_BANKED]);
endmodule

/* File: bench/atre_mem_model.sv */
`timescale 1ns/10ps
module atre_mem_model (
    // clock
    input wire logic sys_clk,
    // data memory side
    input wire logic [11:0] dmAddr,
    input wire logic dmRd,
    input wire logic dmWr,
    input wire logic [7:0] dmWdata,
    output logic [7:0] dmRdata,
    // program memory side
    input wire logic [19:0] pmAddr,
    input wire logic pmRd,
    output logic [15:0] pmRdata
);
    logic [7:0] dm [0:4095];

    // word contents follow the address, so no large array is needed
    function automatic logic [15:0] pmWord(input logic [19:0] a);
        return {a[7:0] ^ a[19:12], a[7:0] ^ a[15:8] ^ 8'h3c};
    endfunction

    initial begin
        dmRdata = 8'h00;
        pmRdata = 16'h0000;
    end

    // answers stand one cycle only; the lines then toggle so a late sample is caught
    always @(posedge sys_clk) begin
        if (dmWr) begin
            dm[dmAddr] <= dmWdata;
        end
        dmRdata <= dmRd ? dm[dmAddr] : ~dmRdata;
        pmRdata <= pmRd ? pmWord(pmAddr) : ~pmRdata;
    end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/10ps
`define ATRE_CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; \
    $display("Error at %0t: mismatch got %h expected %h", $time, g, e); end end
module tb;
    logic sys_clk, sys_rst, regWr, regRd, instrValid, busy, dmRd, dmWr, pmRd;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, dmWdata, dmRdata;
    logic [15:0] instrWord, pmRdata;
    logic [11:0] dmAddr;
    logic [19:0] pmAddr;
    int badCount = 0;
    int nCompared = 0;

    always #20 sys_clk = ~sys_clk;

    atre_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .instrValid(instrValid), .instrWord(instrWord), .busy(busy),
        .dmAddr(dmAddr), .dmRd(dmRd), .dmWr(dmWr), .dmWdata(dmWdata),
        .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRd(pmRd), .pmRdata(pmRdata));

    atre_mem_model mem (.sys_clk(sys_clk), .dmAddr(dmAddr), .dmRd(dmRd), .dmWr(dmWr),
        .dmWdata(dmWdata), .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRd(pmRd),
        .pmRdata(pmRdata));

    function automatic logic [15:0] pmRef(input logic [19:0] a);
        return {a[7:0] ^ a[19:12], a[7:0] ^ a[15:8] ^ 8'h3c};
    endfunction

    // returns {negative, overflow, zero, digit carry, carry, sum}
    function automatic logic [12:0] addRef(input logic [7:0] a, b, input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        `ATRE_CHK(regRdata, e)
    endtask

    // offers one word and counts the cycles that busy stands
    task automatic run(input logic [15:0] w, input int cyc);
        int n;
        @(posedge sys_clk);
        instrWord <= w;
        instrValid <= 1'b1;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `ATRE_CHK(n, cyc)
    endtask

    task automatic addCase(input logic [7:0] acc, fv, input logic c, d, a,
                           input logic [7:0] f, input logic [11:0] where);
        logic [12:0] r;
        r = addRef(acc, fv, c);
        mem.dm[where] = fv;
        wr(4'h0, acc);
        wr(4'h1, {7'h00, c});
        run({6'h08, d, a, f}, 4);
        rd(4'h1, {3'h0, r[12:8]});
        if (d) begin
            `ATRE_CHK(mem.dm[where], r[7:0])
            rd(4'h0, acc);
        end else begin
            rd(4'h0, r[7:0]);
        end
    endtask

    task automatic andCase(input logic [7:0] acc, k);
        logic [7:0] r;
        r = acc & k;
        wr(4'h0, acc);
        wr(4'h1, 8'h0b);
        run({8'h0b, k}, 4);
        rd(4'h0, r);
        rd(4'h1, {3'h0, r[7], 1'b1, r == 8'h00, 2'b11});
    endtask

    task automatic tblCase(input logic [20:0] p, input logic [1:0] mode);
        logic [20:0] at, fin;
        logic [15:0] w;
        at = (mode == 2'h3) ? p + 21'h000001 : p;
        fin = (mode == 2'h2) ? p - 21'h000001 : ((mode == 2'h0) ? p : p + 21'h000001);
        w = pmRef(at[20:1]);
        wr(4'h3, p[7:0]);
        wr(4'h4, p[15:8]);
        wr(4'h5, {3'h0, p[20:16]});
        run({14'h0002, mode}, 8);
        rd(4'h6, at[0] ? w[15:8] : w[7:0]);
        rd(4'h3, fin[7:0]);
        rd(4'h4, fin[15:8]);
        rd(4'h5, {3'h0, fin[20:16]});
    endtask

    task automatic closeOut;
        $display("Comparisons %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        closeOut;
    end

    initial begin
        logic [20:0] ptrs [5];
        logic [1:0] modes [5];
        ptrs = '{21'h00a357, 21'h00a356, 21'h100000, 21'h1fffff, 21'h01a357};
        modes = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        instrValid = 1'b0;
        instrWord = 16'h0000;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0], 8'h00);
        end
        // unmapped place ignores writes and reads zero
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        addCase(8'h4d, 8'h02, 1'b1, 1'b0, 1'b0, 8'h02, 12'h002);
        wr(4'h2, 8'h03);
        addCase(8'hff, 8'h01, 1'b0, 1'b1, 1'b1, 8'h80, 12'h380);
        addCase(8'h7f, 8'h00, 1'b1, 1'b0, 1'b0, 8'ha0, 12'hfa0);
        wr(4'h7, 8'h01);
        wr(4'h8, 8'h23);
        wr(4'h9, 8'h01);
        addCase(8'h10, 8'h21, 1'b0, 1'b0, 1'b0, 8'h10, 12'h133);
        addCase(8'h88, 8'h88, 1'b0, 1'b1, 1'b0, 8'h5f, 12'h182);
        addCase(8'h01, 8'h0f, 1'b0, 1'b0, 1'b0, 8'h60, 12'hf60);
        addCase(8'h80, 8'h7f, 1'b1, 1'b0, 1'b1, 8'h10, 12'h310);
        andCase(8'ha3, 8'h5f);
        andCase(8'h03, 8'h80);
        andCase(8'h83, 8'hf0);
        // unknown opcode: one instruction cycle, accumulator untouched
        run(16'hffff, 4);
        rd(4'h0, 8'h80);
        for (int i = 0; i < 5; i++) begin
            tblCase(ptrs[i], modes[i]);
        end
        closeOut;
    end
endmodule
